// ### remote_line_model.sv
// far-end line receiver: flags a break once the serial line stays low long enough
// assumes one bit time per pclk cycle and an idle-high line
module remote_line_model #(
  parameter int BRK_LEN = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic serial_out_pin,
  output logic      break_seen
);
  // ********
  // break detection
  // ********
  int low_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= serial_out_pin ? 0 : low_cnt + 1;
    end
  end
  assign break_seen = low_cnt >= BRK_LEN;
endmodule : remote_line_model

// ### uart_evt_pkg.sv
// constants, field layouts and carriers for the event, queue control and link format block
// assumes a single pclk domain and an apb master on the register side
package uart_evt_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_EVENT_FIFO = 8'h08;
  localparam logic [7:0] ADDR_LINK_BANK  = 8'h0c;
  localparam logic [7:0] ADDR_SHADOW     = 8'h1c;
  localparam logic [7:0] ADDR_MODE_CFG   = 8'h20;
  localparam logic [7:0] ADDR_LINE_STAT  = 8'h24;
  localparam logic [6:0] BANK_SHADOW     = 7'h64;
  localparam logic [7:0] LINK_RESET      = 8'h00;
  localparam logic [7:0] BANK_RESET      = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int EV_LINK   = 2;
  localparam int EV_MODEM  = 3;
  localparam int EV_DMA    = 4;
  localparam int EV_TX_EMPTY_FLAG  = 5;
  localparam int FC_EN     = 0;
  localparam int FC_RX_SOFT_RESET   = 1;
  localparam int FC_TX_SOFT_RESET   = 2;
  localparam int LS_TX_EMPTY_FLAG  = 6;
  localparam int BANK_EN   = 7;

  // ************************************************************
  // thresholds
  // ************************************************************
  localparam logic [5:0] TX_TH16 [4] = '{6'h01, 6'h03, 6'h09, 6'h0d};
  localparam logic [5:0] TX_TH32 [4] = '{6'h01, 6'h07, 6'h11, 6'h19};
  localparam logic [5:0] RX_TH16 [4] = '{6'h01, 6'h04, 6'h08, 6'h0e};
  localparam logic [5:0] RX_TH32 [4] = '{6'h01, 6'h08, 6'h10, 6'h1a};

  typedef enum logic [2:0] {
    MODE_UART = 3'h0,
    MODE_SHARP = 3'h2,
    MODE_SIR = 3'h3,
    MODE_CIR = 3'h6
  } op_mode_t;

  typedef struct packed {
    logic       stick_parity;
    logic       even_parity_sel;
    logic       parity_enable;
    logic       stop_bits_sel;
    logic [1:0] char_length_sel;
  } char_format_t;

  typedef struct packed {
    logic       rx_error;
    logic       rx_bottom_pe_fe_brk;
    logic       rx_overrun;
    logic       tx_underrun;
    logic       terminal_count;
    logic [3:0] modem_status_low;
    logic       tx_empty_flag;
  } line_events_t;

endpackage : uart_evt_pkg

// ### uart_ir_event_fifo_line_ctrl.sv
// event flags, queue control and link format registers behind an apb slave
// assumes event inputs are synchronous to pclk, queue depth select from outside
// What this block does
// R1: uart sir sharp modes flag receive errors
// R2: queued errors at bottom, overrun immediately
// R3: cir mode flags overrun or underrun
// R4: uart mode flags any low modem bit
// R5: ir modem select one forces flag zero outside uart mode
// R6: terminal count sets dma flag, extended read clears
// R7: transmitter empty flag mirrors line status
// R8: queue control write-only, shares event address
// R9: enable bit enables queues, zero flushes outside cir
// R10: receiver soft reset pulses, self clears
// R11: transmitter soft reset pulses, self clears
// R12: transmit threshold below selected level, extended only
// R13: receive threshold at or above level
// R14: shared address reads bank, shadow reads link
// R15: bank-enable write gating of link format
// R16: link format resets to zero
// R17: format bits ignored in cir mode
// R18: length code gives five to eight bits
// R19: stop bits one, one half, two
// R20: parity odd even stick one zero
// R21: break drives line or ir pins
// R22: software waits empty around break changes
// R23: bank enable picks bank, else zero
// R24: extended select else classic identification
// R25: queue depth from outside, default sixteen
module uart_ir_event_fifo_line_ctrl (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       depth32,
  input  wire uart_evt_pkg::line_events_t line_ev,
  input  wire logic [5:0]                 tx_level,
  input  wire logic [5:0]                 rx_level,
  input  wire logic                       rx_timeout,
  input  wire logic                       tx_data,
  input  wire logic                       ir_tx_data,
  input  wire logic                       ir_mod_en,
  output logic                            serial_out_pin,
  output logic                            ir_tx_pin,
  output logic                            fifo_enable,
  output logic                            rx_soft_reset,
  output logic                            tx_soft_reset,
  output logic                            fifo_flush,
  output logic                            tx_threshold_event,
  output logic                            rx_threshold_event,
  output uart_evt_pkg::char_format_t      char_format,
  output logic [3:0]                      data_bits,
  output logic                            two_stop_bits,
  output logic                            half_stop_bit,
  output logic [6:0]                      active_bank
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic       wr_en;
  logic       rd_en;
  logic [7:0] link_format_q;
  logic [7:0] bank_select_q;
  logic [7:0] mode_cfg_q;
  logic [1:0] tx_th_q;
  logic [1:0] rx_th_q;
  logic       fifo_en_q;
  logic [5:0] ev_q;
  logic       dma_count_event_q;
  logic [1:0] rx_sr_q;
  logic [1:0] tx_sr_q;
  logic       pulse_q;
  logic       extended_select;
  logic       ir_modem_function_select;
  logic       extended;
  logic       cir;
  uart_evt_pkg::op_mode_t mode;
  logic [7:0] event_ident_reg;
  logic [7:0] classic_ident;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic       hit;
  logic       wr_ok;
  uart_evt_pkg::op_mode_t eff_mode;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign wbyte   = pwdata[7:0];
  assign extended_select          = mode_cfg_q[0];
  assign ir_modem_function_select = mode_cfg_q[1];
  assign mode     = uart_evt_pkg::op_mode_t'(mode_cfg_q[4:2]);
  assign extended = extended_select;
  // the mode field only counts once extended operation is selected;
  // a classic port always behaves as a plain uart
  assign eff_mode = extended ? mode : uart_evt_pkg::MODE_UART; // R24
  assign cir      = (eff_mode == uart_evt_pkg::MODE_CIR);

  // ************************************************************
  // mode configuration
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_cfg_q <= 8'h00;
    end else if (wr_en && paddr == uart_evt_pkg::ADDR_MODE_CFG) begin
      // bits above the mode field read back as zero
      mode_cfg_q <= {3'h0, wbyte[4:0]};
    end
  end

  // ************************************************************
  // queue control
  // ************************************************************
  logic fc_wr;
  assign fc_wr = wr_en && paddr == uart_evt_pkg::ADDR_EVENT_FIFO; // R8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_en_q <= 1'b0;
      tx_th_q   <= 2'h0;
      rx_th_q   <= 2'h0;
      pulse_q   <= 1'b0;
    end else begin
      // a zero in the enable bit empties both queues, never in cir
      pulse_q <= fc_wr & ~wbyte[uart_evt_pkg::FC_EN] & ~cir;
      if (fc_wr) begin
        fifo_en_q <= wbyte[uart_evt_pkg::FC_EN]; // R9
        tx_th_q   <= wbyte[5:4];
        rx_th_q   <= wbyte[7:6];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sr_q <= 2'h0;
      tx_sr_q <= 2'h0;
    end else begin
      // single-cycle strobes, so the bits clear themselves
      rx_sr_q <= {1'b0, fc_wr & wbyte[uart_evt_pkg::FC_RX_SOFT_RESET]}; // R10
      tx_sr_q <= {1'b0, fc_wr & wbyte[uart_evt_pkg::FC_TX_SOFT_RESET]}; // R11
    end
  end

  assign fifo_enable   = fifo_en_q | cir; // R9
  assign fifo_flush    = pulse_q; // R9
  assign rx_soft_reset = rx_sr_q[0]; // R10
  assign tx_soft_reset = tx_sr_q[0]; // R11

  // ************************************************************
  // thresholds
  // ************************************************************
  logic [5:0] tx_th;
  logic [5:0] rx_th;
  // depth32 is a static strap that picks the deeper table
  assign tx_th = depth32 ? uart_evt_pkg::TX_TH32[tx_th_q] : uart_evt_pkg::TX_TH16[tx_th_q]; // R25
  assign rx_th = depth32 ? uart_evt_pkg::RX_TH32[rx_th_q] : uart_evt_pkg::RX_TH16[rx_th_q]; // R25

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_threshold_event <= 1'b0;
      rx_threshold_event <= 1'b0;
    end else begin
      // a classic port raises the transmit event only once empty
      tx_threshold_event <= extended ? (tx_level < tx_th) : (tx_level == 6'h00); // R12
      rx_threshold_event <= fifo_enable ? (rx_level >= rx_th) : (rx_level != 6'h00); // R13
    end
  end

  // ************************************************************
  // event flags
  // ************************************************************
  logic link_set;
  logic modem_set;
  logic lsr_err;
  // with queues on, parity, framing and break wait for the queue bottom
  assign lsr_err  = fifo_enable ? (line_ev.rx_bottom_pe_fe_brk | line_ev.rx_overrun)
                                : line_ev.rx_error; // R2
  assign link_set = cir ? (line_ev.rx_overrun | line_ev.tx_underrun) // R3
                        : lsr_err; // R1
  assign modem_set = (|line_ev.modem_status_low) & // R4
                     ~((eff_mode != uart_evt_pkg::MODE_UART) & ir_modem_function_select); // R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= 6'h00;
    end else begin
      // an error in the same cycle as a receiver soft reset still sets the flag
      ev_q[uart_evt_pkg::EV_LINK]  <= link_set | (ev_q[uart_evt_pkg::EV_LINK] & ~rx_soft_reset);
      ev_q[uart_evt_pkg::EV_MODEM] <= modem_set; // R4
      ev_q[1:0] <= {tx_threshold_event, rx_threshold_event | rx_timeout};
      ev_q[uart_evt_pkg::EV_TX_EMPTY_FLAG] <= line_ev.tx_empty_flag; // R7
      ev_q[uart_evt_pkg::EV_DMA] <= 1'b0;
    end
  end

  logic ev_rd;
  assign ev_rd = rd_en && paddr == uart_evt_pkg::ADDR_EVENT_FIFO;

  // terminal count wins over a clearing read in the same cycle;
  // only the extended view clears the flag on read

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_count_event_q <= 1'b0;
    end else if (line_ev.terminal_count) begin
      dma_count_event_q <= 1'b1; // R6
    end else if (ev_rd && extended) begin
      dma_count_event_q <= 1'b0; // R6
    end
  end

  assign event_ident_reg = {2'b00, ev_q[uart_evt_pkg::EV_TX_EMPTY_FLAG], dma_count_event_q,
                            ev_q[uart_evt_pkg::EV_MODEM], ev_q[uart_evt_pkg::EV_LINK],
                            ev_q[1:0]}; // R7

  // classic prioritised identification
  always_comb begin
    classic_ident = {fifo_enable, fifo_enable, 6'h01};
    if (ev_q[uart_evt_pkg::EV_LINK]) begin
      classic_ident[3:0] = 4'h6;
    end else if (rx_timeout && fifo_enable) begin
      classic_ident[3:0] = 4'hc;
    end else if (ev_q[0]) begin
      classic_ident[3:0] = 4'h4;
    end else if (ev_q[1]) begin
      classic_ident[3:0] = 4'h2;
    end else if (ev_q[uart_evt_pkg::EV_MODEM]) begin
      classic_ident[3:0] = 4'h0;
    end
  end

  // ************************************************************
  // link format and bank select
  // ************************************************************
  logic lb_wr;
  logic bank1_code;
  assign lb_wr      = wr_en && paddr == uart_evt_pkg::ADDR_LINK_BANK;
  // codes that still select bank 1 also write the link format
  assign bank1_code = ~wbyte[6] | wbyte[1] | wbyte[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_format_q <= uart_evt_pkg::LINK_RESET; // R16
      bank_select_q <= uart_evt_pkg::BANK_RESET;
    end else if (lb_wr) begin
      bank_select_q <= wbyte; // R15
      if (!wbyte[uart_evt_pkg::BANK_EN] || bank1_code) begin
        link_format_q <= wbyte; // R15
      end
    end
  end

  assign active_bank = bank_select_q[uart_evt_pkg::BANK_EN] ? bank_select_q[6:0] : 7'h00; // R23

  // ************************************************************
  // format decode
  // ************************************************************
  logic fmt_on;
  assign fmt_on      = ~cir; // R17
  // in cir the format reads as zero so nothing downstream acts on it
  assign char_format = fmt_on ? link_format_q[5:0] : '0; // R17 R20
  always_comb begin
    case (char_format.char_length_sel)
      2'h0:    data_bits = 4'h5; // R18
      2'h1:    data_bits = 4'h6;
      2'h2:    data_bits = 4'h7;
      default: data_bits = 4'h8;
    endcase
  end
  assign half_stop_bit = char_format.stop_bits_sel & (char_format.char_length_sel == 2'h0); // R19
  assign two_stop_bits = char_format.stop_bits_sel & (char_format.char_length_sel != 2'h0); // R19

  // ************************************************************
  // break front end
  // ************************************************************
  logic break_condition;
  assign break_condition = fmt_on & link_format_q[6]; // R21
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
      ir_tx_pin      <= 1'b0;
    end else begin
      serial_out_pin <= (break_condition && eff_mode == uart_evt_pkg::MODE_UART) ? 1'b0 : tx_data; // R21
      // a continuous pulse train is one toggle per clock
      if (break_condition && eff_mode == uart_evt_pkg::MODE_SIR) begin
        ir_tx_pin <= ~ir_tx_pin; // R21
      end else if (break_condition && eff_mode == uart_evt_pkg::MODE_SHARP) begin
        ir_tx_pin <= ir_mod_en ? ~ir_tx_pin : 1'b1; // R21
      end else begin
        // otherwise the pin follows the modulator
        ir_tx_pin <= ir_tx_data;
      end
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rd_byte = 8'h00;
    hit     = 1'b1;
    case (paddr)
      uart_evt_pkg::ADDR_EVENT_FIFO: rd_byte = extended ? event_ident_reg : classic_ident; // R24
      uart_evt_pkg::ADDR_LINK_BANK:  rd_byte = bank_select_q; // R14
      // the shadow copy answers only while its bank is selected
      uart_evt_pkg::ADDR_SHADOW: begin
        hit     = (active_bank == uart_evt_pkg::BANK_SHADOW);
        rd_byte = hit ? link_format_q : 8'h00; // R14
      end
      uart_evt_pkg::ADDR_MODE_CFG:   rd_byte = mode_cfg_q;
      uart_evt_pkg::ADDR_LINE_STAT:  rd_byte = {1'b0, line_ev.tx_empty_flag, 6'h00};
      default:                       hit = 1'b0;
    endcase
  end

  assign prdata  = {24'h000000, rd_byte};

  // ************************************************************
  // error response
  // ************************************************************
  // only three addresses take writes; the shadow copy and the line
  // status are read-only and refuse a write without side effects
  always_comb begin
    case (paddr)
      uart_evt_pkg::ADDR_EVENT_FIFO: wr_ok = 1'b1; // R8
      uart_evt_pkg::ADDR_LINK_BANK:  wr_ok = 1'b1; // R15
      uart_evt_pkg::ADDR_MODE_CFG:   wr_ok = 1'b1;
      default:                       wr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & (pwrite ? ~wr_ok : ~hit);

endmodule : uart_ir_event_fifo_line_ctrl

// ### uart_ir_event_fifo_line_ctrl_properties.sv
// concurrent checks on the queue control and link format ports
// assumes one pclk domain; bound into every instance of the block
module uart_ctrl_properties (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pslverr,
  input wire logic                       rx_soft_reset,
  input wire logic                       tx_soft_reset,
  input wire logic                       fifo_flush,
  input wire uart_evt_pkg::char_format_t char_format,
  input wire logic [3:0]                 data_bits,
  input wire logic                       two_stop_bits,
  input wire logic                       half_stop_bit,
  input wire logic [6:0]                 active_bank
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_fc;
  logic wr_lk;
  assign wr_fc = psel && penable && pwrite && paddr == 8'h08;
  assign wr_lk = psel && penable && pwrite && paddr == 8'h0c;
  chk_rx_soft_pulse: assert property (wr_fc && pwdata[1] |=> rx_soft_reset ##1 !rx_soft_reset)
    else $error("receiver soft reset is not one pulse");
  chk_tx_soft_pulse: assert property (wr_fc && pwdata[2] |=> tx_soft_reset ##1 !tx_soft_reset)
    else $error("transmitter soft reset is not one pulse");
  chk_flush_cause: assert property (fifo_flush |-> $past(wr_fc && !pwdata[0]))
    else $error("queue flush without a disabling write");
  chk_len_decode: assert property (char_format != 6'h00 |->
    data_bits == 4'h5 + 4'(char_format.char_length_sel))
    else $error("data bit count wrong");
  chk_stop_count: assert property ({two_stop_bits, half_stop_bit} == (!char_format.stop_bits_sel ?
    2'h0 : (char_format.char_length_sel == 2'h0 ? 2'h1 : 2'h2)))
    else $error("stop bit count wrong");
  chk_bank_zero: assert property (wr_lk && !pwdata[7] |=> active_bank == 7'h00)
    else $error("bank not zero after plain link write");
  chk_bank_take: assert property (wr_lk && pwdata[7] |=> active_bank == $past(pwdata[6:0]))
    else $error("bank code not taken");
  chk_link_keep: assert property (wr_lk && pwdata[7] && pwdata[6] && pwdata[1:0] == 2'h0
    |=> $stable(char_format))
    else $error("link format changed on bank-only write");
  chk_link_take: assert property (wr_lk && !pwdata[7] |=>
    char_format == $past(pwdata[5:0]) || char_format == 6'h00)
    else $error("link format not written");
  chk_reset_clear: assert property ($rose(presetn) |-> char_format == 6'h00 && active_bank == 7'h00)
    else $error("link format not clear after reset");
  chk_shadow_err: assert property (psel && penable && !pwrite && paddr == 8'h1c
    && active_bank != 7'h64 |-> pslverr)
    else $error("shadow read outside its bank accepted");
  cover property (wr_fc && pwdata[1]);
  cover property (wr_lk && pwdata[7]);
  cover property (fifo_flush);
endmodule : uart_ctrl_properties

bind uart_ir_event_fifo_line_ctrl uart_ctrl_properties u_uart_ctrl_properties (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .rx_soft_reset, .tx_soft_reset,
  .fifo_flush, .char_format, .data_bits, .two_stop_bits, .half_stop_bit, .active_bank);

// ### uart_ir_event_fifo_line_ctrl_tb.sv
// self-checking bench for the event, queue control and link format block
// assumes the checker binds itself and the line model watches the serial line pin
module uart_ir_event_fifo_line_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // signals and helpers
  // ********
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, depth32, erv, a;
  logic        rx_timeout, tx_data, ir_tx_data, ir_mod_en, serial_out_pin, ir_tx_pin;
  logic        fifo_enable, rx_soft_reset, tx_soft_reset, fifo_flush, two_stop_bits;
  logic        half_stop_bit, tx_threshold_event, rx_threshold_event, break_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv, v, seed;
  logic [5:0]  tx_level, rx_level;
  logic [3:0]  data_bits;
  logic [6:0]  active_bank;
  int          error_cnt, checked, j;
  uart_evt_pkg::line_events_t ev;
  uart_evt_pkg::char_format_t char_format;
  localparam logic [5:0] TXT [8] = '{6'h01, 6'h03, 6'h09, 6'h0d, 6'h01, 6'h07, 6'h11, 6'h19};
  localparam logic [5:0] RXT [8] = '{6'h01, 6'h04, 6'h08, 6'h0e, 6'h01, 6'h08, 6'h10, 6'h1a};
  uart_ir_event_fifo_line_ctrl u_uart_ir_event_fifo_line_ctrl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .depth32, .line_ev(ev), .tx_level,
    .rx_level, .rx_timeout, .tx_data, .ir_tx_data, .ir_mod_en, .serial_out_pin, .ir_tx_pin,
    .fifo_enable, .rx_soft_reset, .tx_soft_reset, .fifo_flush, .tx_threshold_event,
    .rx_threshold_event, .char_format, .data_bits, .two_stop_bits, .half_stop_bit, .active_bank);
  remote_line_model u_remote_line_model (.pclk, .presetn, .serial_out_pin, .break_seen);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [1:0] exp_stop(input logic [2:0] f);
    return !f[2] ? 2'h0 : (f[1:0] == 2'h0 ? 2'h1 : 2'h2);
  endfunction : exp_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // pulsed events last one cycle, modem and empty levels stay through the read
  task automatic evt(input logic [9:0] e, input int b, input logic x);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= e & 10'h01f;
    @(posedge pclk);
    apb(1'h0, 8'h08, 32'h0);
    ev <= '0;
    chk(rdv[b], x);
  endtask : evt
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ********
  // scenarios
  // ********
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, depth32, rx_timeout, ir_tx_data, ir_mod_en} = '0;
    {paddr, pwdata, tx_level, rx_level, ev} = '0;
    tx_data = 1'h1;
    seed = 32'had50eb17;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h0c, 32'h0);
    chk(rdv, 32'h0);
    chk(char_format, 6'h00);
    apb(1'h0, 8'h1c, 32'h0);
    chk(erv, 1'h1);
    apb(1'h0, 8'h30, 32'h0);
    chk(erv, 1'h1);
    for (int i = 0; i < 16; i++) begin
      v = rnd() & 32'h08;
      v[5:4] = i[3:2];
      v[2:0] = i[2:0];
      apb(1'h1, 8'h0c, v);
      apb(1'h0, 8'h0c, 32'h0);
      chk(rdv, v);
      chk(char_format, v[5:0]);
      chk(data_bits, 4'h5 + v[1:0]);
      chk({two_stop_bits, half_stop_bit}, exp_stop(v[2:0]));
      chk(active_bank, 7'h00);
    end
    apb(1'h1, 8'h0c, 32'he4);
    @(negedge pclk);
    chk({active_bank, char_format}, {7'h64, v[5:0]});
    apb(1'h0, 8'h1c, 32'h0);
    chk(rdv, v);
    apb(1'h1, 8'h0c, 32'h83);
    @(negedge pclk);
    chk({active_bank, char_format}, {7'h03, 6'h03});
    apb(1'h1, 8'h08, 32'h07);
    @(negedge pclk);
    chk({rx_soft_reset, tx_soft_reset, fifo_enable}, 3'h7);
    @(negedge pclk);
    chk({rx_soft_reset, tx_soft_reset}, 2'h0);
    apb(1'h1, 8'h08, 32'h00);
    @(negedge pclk);
    chk({fifo_flush, fifo_enable}, 2'h2);
    apb(1'h1, 8'h20, 32'h01);
    evt(10'h200, 2, 1'h1);
    apb(1'h1, 8'h08, 32'h03);
    evt(10'h200, 2, 1'h0);
    evt(10'h100, 2, 1'h1);
    apb(1'h1, 8'h08, 32'h03);
    evt(10'h080, 2, 1'h1);
    evt(10'h010, 3, 1'h1);
    evt(10'h001, 5, 1'h1);
    evt(10'h000, 5, 1'h0);
    evt(10'h020, 4, 1'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk(rdv[4], 1'h0);
    apb(1'h1, 8'h20, 32'h0f);
    evt(10'h010, 3, 1'h0);
    apb(1'h1, 8'h20, 32'h0d);
    evt(10'h010, 3, 1'h1);
    apb(1'h1, 8'h20, 32'h19);
    apb(1'h1, 8'h08, 32'h02);
    @(negedge pclk);
    chk({fifo_flush, fifo_enable, char_format}, 8'h40);
    evt(10'h040, 2, 1'h1);
    apb(1'h1, 8'h20, 32'h01);
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      j = {v[0], k[1:0]};
      depth32 <= v[0];
      apb(1'h1, 8'h08, {24'h0, k[1:0], k[1:0], 4'h1});
      tx_level <= TXT[j] - 6'h01;
      rx_level <= RXT[j];
      repeat (3) @(posedge pclk);
      chk({tx_threshold_event, rx_threshold_event}, 2'h3);
      tx_level <= TXT[j];
      rx_level <= RXT[j] - 6'h01;
      repeat (3) @(posedge pclk);
      chk({tx_threshold_event, rx_threshold_event}, 2'h0);
    end
    ev <= 10'h001;
    do begin
      apb(1'h0, 8'h24, 32'h0);
    end while (rdv[6] !== 1'h1);
    chk(rdv, 32'h40);
    apb(1'h1, 8'h0c, 32'h40);
    repeat (10) @(posedge pclk);
    chk({serial_out_pin, break_seen}, 2'h1);
    apb(1'h1, 8'h20, 32'h09);
    repeat (3) @(posedge pclk);
    chk(ir_tx_pin, 1'h1);
    apb(1'h1, 8'h20, 32'h0d);
    repeat (3) @(posedge pclk);
    a = ir_tx_pin;
    @(posedge pclk);
    chk(ir_tx_pin ^ a, 1'h1);
    ir_mod_en <= 1'h1;
    apb(1'h1, 8'h20, 32'h09);
    repeat (3) @(posedge pclk);
    a = ir_tx_pin;
    @(posedge pclk);
    chk({serial_out_pin, ir_tx_pin ^ a}, 2'h3);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h0c, 32'h0);
    chk(rdv, 32'h0);
    chk({serial_out_pin, char_format}, 7'h40);
    tally_and_finish();
  end
endmodule : uart_ir_event_fifo_line_ctrl_tb
